// file: hw/qtm_pkg.sv
// qtm_pkg: constants and state type for the quad interval timer
// assumes a 32-bit classic wishbone slave, one 200 MHz clock
package qtm_pkg;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [15:0] QTM_IDX_CTRL_BASE = 16'hF360;
	localparam logic [15:0] QTM_IDX_START = 16'hF370;
	localparam logic [15:0] QTM_IDX_STOP = 16'hF372;
	localparam logic [15:0] QTM_IDX_STATUS = 16'hF374;
	localparam logic [15:0] QTM_IDX_COUNT_BASE = 16'hF380;
	localparam logic [15:0] QTM_IDX_MATCH_BASE = 16'hF388;
	localparam logic [15:0] QTM_IDX_STEP = 16'h0002;

	// ==========================================================
	// control field positions
	localparam int QTM_CTRL_ONESHOT = 7;
	localparam int QTM_CTRL_POLARITY = 6;
	localparam int QTM_CTRL_DIV_HI = 5;
	localparam int QTM_CTRL_DIV_LO = 3;
	localparam int QTM_CTRL_SRC_HI = 1;
	localparam int QTM_CTRL_SRC_LO = 0;
	localparam logic [7:0] QTM_CTRL_WMASK = 8'hFB;

	// ==========================================================
	// source codes and counts
	localparam logic [1:0] QTM_SRC_SLOW = 2'h0;
	localparam logic [1:0] QTM_SRC_FAST = 2'h1;
	localparam logic [1:0] QTM_SRC_EXT = 2'h3;
	localparam logic [2:0] QTM_DIV_RSVD = 3'h7;
	localparam int QTM_NUM = 4;
	localparam logic [15:0] QTM_COUNT_CLEAR = 16'h0000;

	// ==========================================================
	// complete block state
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [3:0][7:0] ctrl;
		logic [3:0][15:0] cnt;
		logic [3:0][15:0] mat;
		logic [3:0][5:0] pre;
		logic [3:0] run;
		logic [3:0] pend;
		logic [3:0] srcp;
		logic [3:0] tog;
		logic [3:0] irq;
		logic [3:0] out;
	} qtm_state_t;

	localparam qtm_state_t QTM_RESET_STATE = '0;

endpackage : qtm_pkg

// file: hw/qtm_timer.sv
// qtm_timer: four 16-bit interval timers behind a wishbone slave
// assumes timer clock inputs are synchronous levels sampled on clk_i
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] control bit 7 picks one-shot mode
// [R2] control bit 6 sets output polarity
// [R3] bits 5..3 divide source, code 7 undivided
// [R4] bits 1..0 pick slow, fast or external
// [R5] four timers share start, stop, status bits
// [R6] start bit one begins counting
// [R7] stop bit requests halt, ignored when stopped
// [R8] all timers stopped after reset
// [R9] status bit shows counting or stopped
// [R10] counter advances on selected falling tick
// [R11] match raises interrupt, counter returns zero
// [R12] after stop, one more tick then halt
// [R13] match may still fire on last tick
// [R14] restart keeps value, counter write zeroes
// [R15] period is match value plus one
// [R16] later periods exactly constant
// [R17] one-shot clears status on match
// [R18] software changes control only while stopped; control writes are also accepted while counting
// [R19] readable counter and data registers, reset zero
module qtm_timer
	import qtm_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [17:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// timer clock sources
	input wire logic slow_clock_i,
	input wire logic fast_osc_clock_i,
	input wire logic ext_clock_i,
	// timer events
	output logic [3:0] match_interrupt_o,
	output logic [3:0] timer_output_o
);

	// ==========================================================
	// helpers
	function automatic logic hit(input logic [17:0] a,
		input logic [15:0] idx);
		return a == {idx, 2'h0};
	endfunction : hit

	function automatic logic [15:0] idx_of(input logic [15:0] base,
		input int i);
		return base + 16'(i) * QTM_IDX_STEP;
	endfunction : idx_of

	function automatic logic [5:0] div_mask(input logic [2:0] d);
		if (d == QTM_DIV_RSVD) begin
			return 6'h00;
		end
		return 6'((7'h01 << d) - 7'h01);
	endfunction : div_mask

	function automatic logic pick_src(input logic [1:0] c,
		input logic s, input logic f, input logic e);
		logic r;
		r = s;
		if (c == QTM_SRC_FAST) begin
			r = f;
		end else if (c == QTM_SRC_EXT) begin
			r = e;
		end
		return r;
	endfunction : pick_src

	// ==========================================================
	// state and next state
	qtm_state_t s_q;
	qtm_state_t s_d;
	logic acc;
	logic wr;
	logic [3:0] tk;
	logic [3:0] src;
	logic [5:0] m;

	always_comb begin
		s_d = s_q;
		tk = '0;
		src = '0;
		m = '0;
		acc = cyc_i && stb_i && !s_q.ack;
		wr = acc && we_i;
		s_d.ack = acc;
		s_d.dat = '0;
		s_d.irq = '0;
		if (acc && !we_i && hit(adr_i, QTM_IDX_STATUS)) begin
			s_d.dat = {28'h0000000, s_q.run}; // R9 R5
		end
		for (int i = 0; i < QTM_NUM; i++) begin
			src[i] = pick_src(s_q.ctrl[i][QTM_CTRL_SRC_HI:QTM_CTRL_SRC_LO],
				slow_clock_i, fast_osc_clock_i, ext_clock_i); // R4
			s_d.srcp[i] = src[i];
			m = div_mask(s_q.ctrl[i][QTM_CTRL_DIV_HI:QTM_CTRL_DIV_LO]);
			if (s_q.srcp[i] && !src[i]) begin
				s_d.pre[i] = s_q.pre[i] + 6'h01;
				tk[i] = (s_q.pre[i] & m) == m; // R3
			end
			if (tk[i] && s_q.run[i]) begin // R10
				if (s_q.cnt[i] == s_q.mat[i]) begin
					s_d.cnt[i] = QTM_COUNT_CLEAR; // R11 R15 R16
					s_d.irq[i] = 1'b1; // R11 R13
					s_d.tog[i] = !s_q.tog[i];
					if (s_q.ctrl[i][QTM_CTRL_ONESHOT]) begin
						s_d.run[i] = 1'b0; // R1 R17
					end
				end else begin
					s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
				end
				if (s_q.pend[i]) begin
					s_d.run[i] = 1'b0; // R12
					s_d.pend[i] = 1'b0;
				end
			end
			if (wr && sel_i[0] && dat_i[i]) begin
				if (hit(adr_i, QTM_IDX_START)) begin
					s_d.run[i] = 1'b1; // R6 R14
					s_d.pend[i] = 1'b0;
				end
				if (hit(adr_i, QTM_IDX_STOP) && s_d.run[i]) begin
					s_d.pend[i] = 1'b1; // R7
				end
			end
			if (hit(adr_i, idx_of(QTM_IDX_CTRL_BASE, i))) begin
				if (wr && sel_i[0]) begin
					s_d.ctrl[i] = dat_i[7:0] & QTM_CTRL_WMASK; // R18
				end
				if (acc && !we_i) begin
					s_d.dat = {24'h000000, s_q.ctrl[i]};
				end
			end
			if (hit(adr_i, idx_of(QTM_IDX_COUNT_BASE, i))) begin
				if (wr) begin
					s_d.cnt[i] = QTM_COUNT_CLEAR; // R14
					s_d.tog[i] = 1'b0;
				end
				if (acc && !we_i) begin
					s_d.dat = {16'h0000, s_q.cnt[i]}; // R19
				end
			end
			if (hit(adr_i, idx_of(QTM_IDX_MATCH_BASE, i))) begin
				if (wr && sel_i[0]) begin
					s_d.mat[i][7:0] = dat_i[7:0]; // R19
				end
				if (wr && sel_i[1]) begin
					s_d.mat[i][15:8] = dat_i[15:8];
				end
				if (acc && !we_i) begin
					s_d.dat = {16'h0000, s_q.mat[i]};
				end
			end
			s_d.out[i] = s_d.tog[i] ^ s_d.ctrl[i][QTM_CTRL_POLARITY]; // R2
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= QTM_RESET_STATE; // R8
		end else begin
			s_q <= s_d;
		end
	end

	assign ack_o = s_q.ack;
	assign dat_o = s_q.dat;
	assign match_interrupt_o = s_q.irq;
	assign timer_output_o = s_q.out;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence seq_stop_wr;
		wr && sel_i[0] && dat_i[0] && hit(adr_i, QTM_IDX_STOP);
	endsequence

	sequence seq_last_tick;
		s_q.pend[0] && s_q.run[0] && tk[0];
	endsequence

	logic plain_acc;
	assign plain_acc = wr && ((sel_i[0] && hit(adr_i, QTM_IDX_START)) ||
		hit(adr_i, idx_of(QTM_IDX_COUNT_BASE, 0)));

	a_ack_single: assert property (s_q.ack |=> !s_q.ack)
		else $error("ack held longer than one cycle");
	a_reset_stopped: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> (s_q.run == 4'h0 && s_q.pend == 4'h0)) // R8
		else $error("timers not stopped after reset");
	a_start_runs: assert property (wr && sel_i[0] && dat_i[0] &&
		hit(adr_i, QTM_IDX_START) |=> s_q.run[0] && !s_q.pend[0]) // R6
		else $error("start did not set counting");
	a_stop_idle_ignored: assert property (seq_stop_wr ##0 !s_q.run[0]
		|=> !s_q.pend[0] && !s_q.run[0]) // R7
		else $error("stop on idle timer not ignored");
	a_stop_one_more: assert property (seq_stop_wr ##0 s_q.run[0] &&
		!tk[0] |=> s_q.run[0] && s_q.pend[0]) // R12
		else $error("stop halted before next tick");
	a_last_tick_halts: assert property (seq_last_tick ##0 !plain_acc
		|=> !s_q.run[0]) // R12
		else $error("timer ran past last tick");
	a_count_step: assert property (tk[0] && s_q.run[0] && !plain_acc &&
		s_q.cnt[0] != s_q.mat[0]
		|=> s_q.cnt[0] == $past(s_q.cnt[0]) + 16'h0001) // R10
		else $error("counter did not step on tick");
	a_match_wrap: assert property (tk[0] && s_q.run[0] && !plain_acc &&
		s_q.cnt[0] == s_q.mat[0]
		|=> s_q.cnt[0] == QTM_COUNT_CLEAR && s_q.irq[0]) // R11
		else $error("match did not wrap and interrupt");
	a_oneshot_stop: assert property (tk[0] && s_q.run[0] && !plain_acc &&
		s_q.cnt[0] == s_q.mat[0] && s_q.ctrl[0][QTM_CTRL_ONESHOT]
		|=> !s_q.run[0]) // R17
		else $error("one-shot kept counting after match");
	a_irq_cause: assert property (s_q.irq[0] |-> $past(tk[0]) &&
		$past(s_q.run[0])) // R13
		else $error("interrupt without counted tick");
	a_count_clear: assert property (wr &&
		hit(adr_i, idx_of(QTM_IDX_COUNT_BASE, 0))
		|=> s_q.cnt[0] == QTM_COUNT_CLEAR) // R14
		else $error("counter write did not clear");
	a_status_read: assert property (acc && !we_i &&
		hit(adr_i, QTM_IDX_STATUS) |=> s_q.ack &&
		s_q.dat[3:0] == $past(s_q.run) && s_q.dat[31:4] == 28'h0000000) // R9
		else $error("status read wrong");
	a_idle_frozen: assert property (!s_q.run[0] && !plain_acc
		|=> $stable(s_q.cnt[0])) // R14
		else $error("stopped counter moved");

	// ==========================================================
	// sequences for the wider checks
	sequence seq_fall_t0;
		s_q.srcp[0] && !src[0];
	endsequence

	sequence seq_fall_t3;
		s_q.srcp[3] && !src[3];
	endsequence

	sequence seq_start_t3;
		wr && sel_i[0] && dat_i[3] && hit(adr_i, QTM_IDX_START);
	endsequence

	logic quiet_t3;
	assign quiet_t3 = wr && ((sel_i[0] && hit(adr_i, QTM_IDX_START)) ||
		hit(adr_i, idx_of(QTM_IDX_COUNT_BASE, 3)));

	// ==========================================================
	// reset and bus checks
	a_reset_outputs: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> s_q.irq == 4'h0 && s_q.out == 4'h0 && !s_q.ack) // R8
		else $error("outputs not cleared by reset");
	a_reset_regs: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> s_q.cnt == '0 && s_q.mat == '0 && s_q.ctrl == '0) // R19
		else $error("registers not cleared by reset");
	a_ack_needs_req: assert property (s_q.ack |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_dat_idle_zero: assert property (!s_q.ack |-> s_q.dat == 32'h00000000)
		else $error("read data not zero while idle");
	a_start_reads_zero: assert property (acc && !we_i &&
		hit(adr_i, QTM_IDX_START) |=> s_q.dat == 32'h00000000) // R6
		else $error("start register read not zero");
	a_ctrl_read: assert property (acc && !we_i &&
		hit(adr_i, idx_of(QTM_IDX_CTRL_BASE, 0))
		|=> s_q.dat == {24'h000000, $past(s_q.ctrl[0])}) // R1
		else $error("control read wrong");
	a_count_read: assert property (acc && !we_i &&
		hit(adr_i, idx_of(QTM_IDX_COUNT_BASE, 0))
		|=> s_q.dat == {16'h0000, $past(s_q.cnt[0])}) // R19
		else $error("counter read wrong");
	a_match_read: assert property (acc && !we_i &&
		hit(adr_i, idx_of(QTM_IDX_MATCH_BASE, 0))
		|=> s_q.dat == {16'h0000, $past(s_q.mat[0])}) // R19
		else $error("match read wrong");
	a_match_hold: assert property (!(wr && hit(adr_i,
		idx_of(QTM_IDX_MATCH_BASE, 0))) |=> $stable(s_q.mat[0])) // R19
		else $error("match value changed without write");
	a_ctrl_gap_zero: assert property (s_q.ctrl[0][2] == 1'b0 &&
		s_q.ctrl[3][2] == 1'b0)
		else $error("reserved control bit set");

	// ==========================================================
	// clock selection and prescaler checks
	a_src_slow: assert property (s_q.ctrl[0][QTM_CTRL_SRC_HI:QTM_CTRL_SRC_LO]
		== QTM_SRC_SLOW |-> src[0] == slow_clock_i) // R4
		else $error("slow source not selected");
	a_src_fast: assert property (s_q.ctrl[0][QTM_CTRL_SRC_HI:QTM_CTRL_SRC_LO]
		== QTM_SRC_FAST |-> src[0] == fast_osc_clock_i) // R4
		else $error("fast source not selected");
	a_src_ext: assert property (s_q.ctrl[0][QTM_CTRL_SRC_HI:QTM_CTRL_SRC_LO]
		== QTM_SRC_EXT |-> src[0] == ext_clock_i) // R4
		else $error("external source not selected");
	a_src_spare: assert property (s_q.ctrl[0][QTM_CTRL_SRC_HI:QTM_CTRL_SRC_LO]
		== 2'h2 |-> src[0] == slow_clock_i) // R4
		else $error("spare source code not slow");
	a_prescale_step: assert property (seq_fall_t0
		|=> s_q.pre[0] == $past(s_q.pre[0]) + 6'h01) // R3
		else $error("prescaler missed a falling edge");
	a_prescale_hold: assert property (!(s_q.srcp[0] && !src[0])
		|=> $stable(s_q.pre[0])) // R3
		else $error("prescaler moved without edge");
	a_div_one: assert property (seq_fall_t0 ##0
		s_q.ctrl[0][QTM_CTRL_DIV_HI:QTM_CTRL_DIV_LO] == 3'h0 |-> tk[0]) // R3
		else $error("undivided source did not tick");
	a_div_spare: assert property (seq_fall_t0 ##0 s_q.ctrl[0][QTM_CTRL_DIV_HI:
		QTM_CTRL_DIV_LO] == QTM_DIV_RSVD |-> tk[0]) // R3
		else $error("spare divider code not undivided");
	a_div_two: assert property (seq_fall_t0 ##0 !s_q.pre[0][0] &&
		s_q.ctrl[0][QTM_CTRL_DIV_HI:QTM_CTRL_DIV_LO] == 3'h1 |-> !tk[0]) // R3
		else $error("divide by two ticked early");
	a_tick_needs_fall: assert property (tk[0] |-> seq_fall_t0) // R10
		else $error("tick without falling edge");

	// ==========================================================
	// run state and output checks
	a_pend_needs_run: assert property (s_q.pend[0] |-> s_q.run[0]) // R7
		else $error("stop pending on stopped timer");
	a_run_cause: assert property ($rose(s_q.run[0]) |-> $past(wr &&
		sel_i[0] && dat_i[0] && hit(adr_i, QTM_IDX_START))) // R6
		else $error("timer started without start write");
	a_halt_cause: assert property ($fell(s_q.run[0]) && !$past(rst_i)
		|-> $past(tk[0])) // R12
		else $error("timer halted without tick");
	a_irq_pulse: assert property (s_q.irq[0] |=> !s_q.irq[0]) // R11
		else $error("interrupt longer than one cycle");
	a_out_toggle: assert property (s_q.irq[0] && $stable(s_q.ctrl[0]) &&
		!$past(plain_acc) |-> s_q.out[0] != $past(s_q.out[0])) // R2
		else $error("output did not toggle on match");
	a_out_level: assert property (s_q.out[0] ==
		(s_q.tog[0] ^ s_q.ctrl[0][QTM_CTRL_POLARITY])) // R2
		else $error("output polarity wrong");

	// ==========================================================
	// timer three checks
	a_start_runs_t3: assert property (seq_start_t3 |=> s_q.run[3]) // R5
		else $error("start did not set timer three");
	a_step_t3: assert property (tk[3] && s_q.run[3] && !quiet_t3 &&
		s_q.cnt[3] != s_q.mat[3]
		|=> s_q.cnt[3] == $past(s_q.cnt[3]) + 16'h0001) // R10
		else $error("timer three did not step");
	a_wrap_t3: assert property (tk[3] && s_q.run[3] && !quiet_t3 &&
		s_q.cnt[3] == s_q.mat[3]
		|=> s_q.cnt[3] == QTM_COUNT_CLEAR && s_q.irq[3]) // R11
		else $error("timer three did not wrap");
	a_oneshot_t3: assert property (tk[3] && s_q.run[3] && !quiet_t3 &&
		s_q.cnt[3] == s_q.mat[3] && s_q.ctrl[3][QTM_CTRL_ONESHOT]
		|=> !s_q.run[3]) // R17
		else $error("timer three one-shot kept counting");
	a_irq_cause_t3: assert property (s_q.irq[3] |-> $past(tk[3]) &&
		$past(s_q.run[3])) // R13
		else $error("timer three interrupt without tick");
	a_tick_fall_t3: assert property (tk[3] |-> seq_fall_t3) // R10
		else $error("timer three tick without edge");
	a_idle_t3: assert property (!s_q.run[3] && !quiet_t3
		|=> $stable(s_q.cnt[3])) // R14
		else $error("stopped timer three moved");
	a_pend_run_t3: assert property (s_q.pend[3] |-> s_q.run[3]) // R7
		else $error("timer three stop pending while stopped");

endmodule : qtm_timer

`default_nettype wire

// file: sim/qtm_tb.sv
// qtm_tb: directed bench for the quad interval timer
// assumes qtm_pkg and qtm_timer compiled first, one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import qtm_pkg::*;
	// ==========================================================
	// signals
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [17:0] adr = '0;
	logic [31:0] wdat = '0, rdat;
	logic ack;
	logic [2:0] src = 3'h7;
	logic [3:0] irq, tout;
	logic [7:0] ic = '0, ib = '0;
	int error_cnt = 0, checks_done = 0, cyc_n = 0;
	qtm_timer i_qtm_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .slow_clock_i(src[0]),
		.fast_osc_clock_i(src[1]), .ext_clock_i(src[2]),
		.match_interrupt_o(irq), .timer_output_o(tout));
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n++;
		if (irq[0] === 1'b1) ic <= ic + 8'h01;
		if (irq[3] === 1'b1) ib <= ib + 8'h01;
		if (cyc_n > 40000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// ==========================================================
	// helpers
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			error_cnt++;
		end
	endtask : chk
	task automatic wb(input logic w, input logic [15:0] ix,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'h0};
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic wr(input logic [15:0] ix, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, ix, d, q);
	endtask : wr
	task automatic rd(input logic [15:0] ix, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, ix, 32'h0, q);
		chk(q, e);
	endtask : rd
	task automatic fall(input logic [2:0] m);
		@(posedge clk_i);
		src <= ~m;
		repeat (3) @(posedge clk_i);
		src <= 3'h7;
		repeat (3) @(posedge clk_i);
	endtask : fall
	task automatic setup(input logic [7:0] v);
		wr(QTM_IDX_STOP, 32'h1);
		repeat (64) fall(3'h7);
		wr(QTM_IDX_CTRL_BASE, 32'h0);
		wr(QTM_IDX_CTRL_BASE, {24'h0, v});
		wr(QTM_IDX_COUNT_BASE, 32'h0);
		wr(QTM_IDX_START, 32'h1);
	endtask : setup
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rd(QTM_IDX_STATUS, 32'h0);
		rd(QTM_IDX_COUNT_BASE, 32'h0);
		rd(QTM_IDX_MATCH_BASE + 16'h0006, 32'h0);
		rd(QTM_IDX_CTRL_BASE, 32'h0);
		rd(16'h0100, 32'h0);
		wr(QTM_IDX_CTRL_BASE, 32'hFF);
		rd(QTM_IDX_CTRL_BASE, 32'hFB);
		wr(QTM_IDX_CTRL_BASE, 32'h40);
		chk(tout, 4'h1);
		wr(QTM_IDX_CTRL_BASE, 32'h0);
		$display("test reset and control done");
	endtask : t_reset
	task automatic t_period();
		wr(QTM_IDX_MATCH_BASE, 32'h3);
		wr(QTM_IDX_START, 32'h1);
		rd(QTM_IDX_STATUS, 32'h1);
		repeat (3) fall(3'h1);
		chk(ic, 8'h0);
		fall(3'h1);
		chk(ic, 8'h1);
		chk(tout, 4'h1);
		rd(QTM_IDX_COUNT_BASE, 32'h0);
		repeat (4) fall(3'h1);
		chk(ic, 8'h2);
		fall(3'h1);
		wr(QTM_IDX_STOP, 32'h1);
		rd(QTM_IDX_STATUS, 32'h1);
		fall(3'h1);
		rd(QTM_IDX_STATUS, 32'h0);
		fall(3'h1);
		rd(QTM_IDX_COUNT_BASE, 32'h2);
		wr(QTM_IDX_STOP, 32'h1);
		rd(QTM_IDX_STATUS, 32'h0);
		wr(QTM_IDX_START, 32'h1);
		fall(3'h1);
		rd(QTM_IDX_COUNT_BASE, 32'h3);
		wr(QTM_IDX_STOP, 32'h1);
		fall(3'h1);
		chk(ic, 8'h3);
		rd(QTM_IDX_STATUS, 32'h0);
		wr(QTM_IDX_START, 32'h1);
		fall(3'h1);
		wr(QTM_IDX_COUNT_BASE, 32'h1234);
		rd(QTM_IDX_COUNT_BASE, 32'h0);
		$display("test period and stop done");
	endtask : t_period
	task automatic t_oneshot();
		wr(QTM_IDX_CTRL_BASE + 16'h0006, 32'h80);
		wr(QTM_IDX_MATCH_BASE + 16'h0006, 32'h1);
		wr(QTM_IDX_START, 32'h8);
		rd(QTM_IDX_STATUS, 32'h9);
		repeat (2) fall(3'h1);
		chk(ib, 8'h1);
		rd(QTM_IDX_STATUS, 32'h1);
		$display("test one-shot done");
	endtask : t_oneshot
	task automatic t_clocks();
		int n;
		logic [2:0] m;
		wr(QTM_IDX_MATCH_BASE, 32'hFFFF);
		for (int d = 0; d < 8; d++) begin
			n = (d == 7) ? 1 : (1 << d);
			setup(8'(d << 3));
			repeat (2 * n) fall(3'h7);
			rd(QTM_IDX_COUNT_BASE, 32'h2);
		end
		for (int s = 0; s < 4; s++) begin
			m = (s == 1) ? 3'h2 : ((s == 3) ? 3'h4 : 3'h1);
			setup(8'(s));
			fall(~m);
			rd(QTM_IDX_COUNT_BASE, 32'h0);
			fall(m);
			rd(QTM_IDX_COUNT_BASE, 32'h1);
		end
		$display("test prescale and source done");
	endtask : t_clocks
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_period();
		t_oneshot();
		t_clocks();
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
